// ### core/cooldown_timer.sv
// Millisecond tick generator and cool-down countdown
module cooldown_timer #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [15:0] duration,
  output logic tick,
  output logic busy,
  output logic done
);

  logic [19:0] pre;
  logic [15:0] remain;
  logic pre_wrap;

  assign pre_wrap = (pre == 20'(TICK_CYCLES - 1));
  assign busy = (remain != 16'h0000);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre <= 20'h00000;
      tick <= 1'b0;
    end else begin
      pre <= pre_wrap ? 20'h00000 : pre + 20'h00001;
      tick <= pre_wrap;
    end
  end

  // A zero duration still gives one tick, so a trip always cools down
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      remain <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= busy && tick && (remain == 16'h0001) && !start;
      if (start) begin
        remain <= (duration == 16'h0000) ? 16'h0001 : duration;
      end else if (busy && tick) begin
        remain <= remain - 16'h0001;
      end
    end
  end

endmodule : cooldown_timer

// ### core/input_sync.sv
// Two-stage synchroniser for a group of pin inputs
module input_sync #(
  parameter int W = 6
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : input_sync

// ### core/motor_io_pkg.sv
// Shared constants, register map and types of the motor relay I/O block
package motor_io_pkg;

  // ==========================================================================
  // Register map (byte offsets on APB)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_COOL_TIME = 12'h004;
  localparam logic [11:0] OFF_STATE = 12'h008;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h00C;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h010;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h014;
  localparam logic [11:0] OFF_MON = 12'h018;

  // ==========================================================================
  // Control register
  typedef enum logic {
    MODE_PASS = 1'b0,
    MODE_OLR = 1'b1
  } mode_e;

  typedef struct packed {
    logic fault_aux_en;
    logic fault_c_en;
    mode_e mode;
  } ctrl_s;

  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [15:0] COOL_TIME_RESET = 16'h0064;

  // ==========================================================================
  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_COOL_DONE = 1;
  localparam int IRQ_WARN = 2;

  // ==========================================================================
  // Process image bit positions (standard control functions)
  localparam int MON_SUM_WARN = 7;
  localparam int MON_SUM_FAULT = 6;
  localparam int MON_OL_WARN = 3;
  localparam int MON_DI_LSB = 10;
  localparam int DI_W = 6;
  localparam int CMD_FAULT_RESET = 6;
  localparam int CMD_EMERG_START = 4;
  localparam int CMD_OUT_C = 15;
  localparam int CMD_OUT_B = 14;
  localparam int CMD_OUT_A = 13;
  localparam int CMD_AUX = 12;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] status;
  } mon_s;

  localparam logic [15:0] CURRENT_MAX_PCT = 16'h0320;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [7:0] FLASH_MS = 8'hFA;

  typedef enum logic [1:0] {
    FS_RUN = 2'b00,
    FS_COOLING = 2'b01,
    FS_LATCHED = 2'b10
  } fault_state_e;

endpackage : motor_io_pkg

// ### core/motor_relay_io.sv
// Relay output, process image and fault logic of the motor protection controller
//
// Overview of operation
// - Current word clamped to 0..800 percent.
// - Overload mode powers up contact A closed, B open.
// - Trip starts cool-down; reset refused until over.
// - Overload mode cooling: contact B energised, A open.
// - Overload mode: C, aux, inputs follow images.
// - Fault outputs ignore command bits, follow fault.
// - Overload mode offers no start/stop or supervision.
// - Fault drives configured fault output C or aux.
// - Fault sets summary fault bit in monitoring image.
// - Fault switches the red lamp on.
// - Fault makes the panel fault indicator flash.
// - Command bits of fault outputs are overridden.
// - Image bit layout is the standard one.
// - Pass-through: outputs and inputs follow the fieldbus.
//
// Local design decisions: register access over APB and the address map.
module motor_relay_io
  import motor_io_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [DI_W-1:0] digital_inputs,
  input wire logic [15:0] cmd_image,
  input wire logic [15:0] motor_current_pct,
  input wire logic overload_trip,
  input wire logic overload_warn,
  output mon_s mon_image,
  output logic relay_output_a,
  output logic relay_output_b,
  output logic relay_output_c,
  output logic aux_supply_output,
  output logic red_led,
  output logic panel_fault_flash
);

  // ==========================================================================
  // Pin inputs
  logic [DI_W-1:0] di_sync;

  input_sync #(.W(DI_W)) u_di_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(digital_inputs),
    .sync_out(di_sync)
  );

  // ==========================================================================
  // APB slave
  ctrl_s ctrl;
  logic [15:0] cool_time;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  fault_state_e fstate;
  fault_state_e next_fstate;
  logic cool_busy;

  wire setup_phase = psel && !penable;
  wire wr_take = psel && penable && pready && pwrite;
  // Every address bit is decoded, so no register answers at an alias
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_cool = (paddr == OFF_COOL_TIME);
  wire hit_state = (paddr == OFF_STATE);
  wire hit_stat = (paddr == OFF_IRQ_STATUS);
  wire hit_clr = (paddr == OFF_IRQ_CLEAR);
  wire hit_en = (paddr == OFF_IRQ_ENABLE);
  wire hit_mon = (paddr == OFF_MON);
  wire hit_any = hit_ctrl | hit_cool | hit_state | hit_stat | hit_clr | hit_en | hit_mon;
  wire [31:0] state_word = {27'h0, cool_busy, fstate, overload_warn, overload_trip};
  wire [31:0] next_prdata = hit_ctrl ? {29'h0, ctrl} :
                            hit_cool ? {16'h0000, cool_time} :
                            hit_state ? state_word :
                            hit_stat ? {29'h0, irq_stat} :
                            hit_en ? {29'h0, irq_en} :
                            hit_mon ? mon_image : 32'h00000000;

  // Answer is prepared in the setup cycle, so every access has zero wait states
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      prdata <= (setup_phase && !pwrite) ? next_prdata : 32'h00000000;
      pslverr <= setup_phase && !hit_any;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= ctrl_s'(CTRL_RESET);
      cool_time <= COOL_TIME_RESET;
      irq_en <= '0;
    end else begin
      if (wr_take && hit_ctrl) ctrl <= ctrl_s'(pwdata[CTRL_W-1:0]);
      if (wr_take && hit_cool) cool_time <= pwdata[15:0];
      if (wr_take && hit_en) irq_en <= pwdata[IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Fault sequencing
  logic cool_tick;
  logic cool_done;
  logic reset_prev;
  logic warn_prev;

  wire fault = (fstate != FS_RUN);
  wire cooling = (fstate == FS_COOLING);
  wire reset_edge = cmd_image[CMD_FAULT_RESET] && !reset_prev;
  wire trip_start = (fstate == FS_RUN) && overload_trip;

  cooldown_timer #(.TICK_CYCLES(TICK_CYCLES_P)) u_cool (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(trip_start),
    .duration(cool_time),
    .tick(cool_tick),
    .busy(cool_busy),
    .done(cool_done)
  );

  // A reset while cooling is dropped, not remembered
  always_comb begin
    next_fstate = fstate;
    unique case (fstate)
      FS_RUN: if (overload_trip) next_fstate = FS_COOLING;
      FS_COOLING: if (cool_done) next_fstate = FS_LATCHED;
      FS_LATCHED: if (reset_edge && !overload_trip) next_fstate = FS_RUN;
      default: next_fstate = FS_LATCHED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fstate <= FS_RUN;
      reset_prev <= 1'b0;
      warn_prev <= 1'b0;
    end else begin
      fstate <= next_fstate;
      reset_prev <= cmd_image[CMD_FAULT_RESET];
      warn_prev <= overload_warn;
    end
  end

  // ==========================================================================
  // Interrupts: set wins over a clear in the same cycle
  wire [IRQ_W-1:0] irq_set = {overload_warn && !warn_prev, cool_done, trip_start};
  wire [IRQ_W-1:0] irq_clr = (wr_take && hit_clr) ? pwdata[IRQ_W-1:0] : '0;
  wire irq_due = |(irq_stat & irq_en);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq <= irq_due;
    end
  end

  // ==========================================================================
  // Output selection
  // Overload mode has no start/stop, checkback, simulation, bus fault or dip paths
  logic [7:0] flash_cnt;
  logic blink;
  wire olr = (ctrl.mode == MODE_OLR);
  wire next_a = olr ? !fault : cmd_image[CMD_OUT_A];
  wire next_b = olr ? (fault || cooling) : cmd_image[CMD_OUT_B];
  wire next_c = ctrl.fault_c_en ? fault : cmd_image[CMD_OUT_C];
  wire next_aux = ctrl.fault_aux_en ? fault : cmd_image[CMD_AUX];
  wire [15:0] next_current = (motor_current_pct > CURRENT_MAX_PCT) ?
                             CURRENT_MAX_PCT : motor_current_pct;
  wire [15:0] next_status = {di_sync, 2'b00, overload_warn, fault, 2'b00,
                             overload_warn, 3'b000};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_cnt <= 8'h00;
      blink <= 1'b0;
    end else if (cool_tick) begin
      flash_cnt <= (flash_cnt == FLASH_MS - 8'h01) ? 8'h00 : flash_cnt + 8'h01;
      if (flash_cnt == FLASH_MS - 8'h01) blink <= !blink;
    end
  end

  // Registered so a glitch on the command word between clock edges never reaches a relay
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      relay_output_a <= 1'b0;
      relay_output_b <= 1'b0;
      relay_output_c <= 1'b0;
      aux_supply_output <= 1'b0;
      red_led <= 1'b0;
      panel_fault_flash <= 1'b0;
      mon_image <= '0;
    end else begin
      relay_output_a <= next_a;
      relay_output_b <= next_b;
      relay_output_c <= next_c;
      aux_supply_output <= next_aux;
      red_led <= fault;
      panel_fault_flash <= fault && blink;
      mon_image <= '{current: next_current, status: next_status};
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_current_clamp: assert property (mon_image.current <= CURRENT_MAX_PCT)
    else $error("monitored current above 800 percent");
  a_powerup_contacts: assert property ((olr && fstate == FS_RUN) |=>
    (relay_output_a && !relay_output_b))
    else $error("healthy overload mode contacts wrong");
  a_trip_cools: assert property ((fstate == FS_RUN && overload_trip) |=>
    (fstate == FS_COOLING && cool_busy))
    else $error("trip did not start cool-down");
  a_reset_refused: assert property ((fstate == FS_COOLING && reset_edge && !cool_done) |=>
    (fstate != FS_RUN))
    else $error("fault cleared during cool-down");
  a_cool_contacts: assert property ((olr && cooling) |=> (!relay_output_a && relay_output_b))
    else $error("contacts wrong while cooling");
  a_inputs_mirror: assert property (mon_image.status[15:MON_DI_LSB] == $past(di_sync))
    else $error("inputs not mirrored in monitoring image");
  a_fault_out_c: assert property (ctrl.fault_c_en |=> relay_output_c == $past(fault))
    else $error("fault output C not driven by fault");
  a_fault_out_aux: assert property ((ctrl.fault_aux_en && fault) |=> aux_supply_output)
    else $error("aux fault output not set on fault");
  a_cmd_override: assert property ((ctrl.fault_c_en && !fault && cmd_image[CMD_OUT_C])
    |=> !relay_output_c)
    else $error("command bit reached a fault output");
  a_pass_follow: assert property ((!olr && !ctrl.fault_c_en) |=>
    (relay_output_a == $past(cmd_image[CMD_OUT_A]) &&
     relay_output_c == $past(cmd_image[CMD_OUT_C])))
    else $error("pass-through outputs do not follow commands");
  a_fault_report: assert property (fault |=>
    (mon_image.status[MON_SUM_FAULT] && red_led))
    else $error("fault not reported");
  a_fault_flash: assert property ((fault && blink) |=> panel_fault_flash)
    else $error("panel indicator not flashing on fault");
  a_warn_bits: assert property (overload_warn |=>
    (mon_image.status[MON_SUM_WARN] && mon_image.status[MON_OL_WARN]))
    else $error("warning bits missing");
  a_irq_level: assert property (irq == $past(irq_due))
    else $error("interrupt level wrong");

  // Bus, interrupt and mode checks
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one access cycle");
  a_err_unmapped: assert property ((setup_phase && !hit_any) |=> (pready && pslverr))
    else $error("unmapped access not flagged");
  a_idle_rdata: assert property (!pready |-> (prdata == 32'h00000000))
    else $error("read data driven outside an access");
  a_set_wins: assert property ((irq_set != '0) |=>
    ((irq_stat & $past(irq_set)) == $past(irq_set)))
    else $error("interrupt event lost");
  a_clear_works: assert property (((irq_clr & ~irq_set) != '0) |=>
    ((irq_stat & $past(irq_clr) & ~$past(irq_set)) == '0))
    else $error("interrupt status not cleared");
  a_olr_no_cmd: assert property (olr |=> (relay_output_a == !$past(fault)))
    else $error("overload mode contact A not from fault state");
  a_olr_fault_b: assert property ((olr && fault) |=>
    relay_output_b)
    else $error("overload mode contact B open on fault");
  a_latched_holds: assert property ((fstate == FS_LATCHED && !reset_edge) |=>
    (fstate == FS_LATCHED))
    else $error("latched fault cleared without reset");
  a_aux_follow: assert property ((!ctrl.fault_aux_en) |=>
    (aux_supply_output == $past(cmd_image[CMD_AUX])))
    else $error("aux output does not follow its command bit");
  a_c_follow: assert property ((!ctrl.fault_c_en) |=>
    (relay_output_c == $past(cmd_image[CMD_OUT_C])))
    else $error("output C does not follow its command bit");
  a_pass_contact_b: assert property (!olr |=>
    (relay_output_b == $past(cmd_image[CMD_OUT_B])))
    else $error("pass-through contact B does not follow command");
  a_current_pass: assert property ((motor_current_pct <= CURRENT_MAX_PCT) |=>
    (mon_image.current == $past(motor_current_pct)))
    else $error("monitored current differs from measured value");
  a_lamp_off: assert property (!fault |=> (!red_led && !panel_fault_flash))
    else $error("fault lamp on without fault");

  c_trip: cover property (fstate == FS_RUN ##1 fstate == FS_COOLING);
  c_recover: cover property (fstate == FS_LATCHED ##1 fstate == FS_RUN);
  c_pass_relay: cover property (!olr && relay_output_c);
  c_irq: cover property ($rose(irq));
  c_reset_dropped: cover property (cooling && reset_edge);

endmodule : motor_relay_io

// ### sim/fieldbus_master.sv
// Fieldbus master model that assembles the cyclic command word
module fieldbus_master
  import motor_io_pkg::*;
(
  input wire logic clk_sys,
  output logic [15:0] cmd_image
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Command image
  logic [3:0] outs = 4'h0;
  logic fault_rst = 1'b0;
  logic emerg = 1'b0;
  // Undefined bits are sent as zero so the device never sees stray commands
  assign cmd_image = {outs, 5'h00, fault_rst, 1'b0, emerg, 4'h0};
  task set_outs(input logic [3:0] v);
    @(posedge clk_sys);
    outs <= v;
  endtask : set_outs
  task set_emerg(input logic v);
    @(posedge clk_sys);
    emerg <= v;
  endtask : set_emerg
  // Held for two cycles so the device sees one clean rising edge
  task pulse_reset;
    @(posedge clk_sys);
    fault_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    fault_rst <= 1'b0;
  endtask : pulse_reset
endmodule : fieldbus_master

// ### sim/motor_relay_io_tb.sv
// Self-checking testbench of the motor relay I/O block
module motor_relay_io_tb
  import motor_io_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err, saw0, saw1;
  logic [5:0] din = 6'h00;
  logic [15:0] cur = 16'h0000;
  logic [15:0] cmd_image;
  logic trip = 1'b0, warn = 1'b0;
  mon_s mon_image;
  logic ra, rb, rc, raux, red_led, flash;
  logic [3:0] outs;
  int fail_count = 0, checked = 0, cycles = 0;
  assign outs = {rc, rb, ra, raux};
  initial forever #5 clk_sys = ~clk_sys;
  // ==========================================================================
  // Instances
  motor_relay_io #(.TICK_CYCLES_P(10)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .digital_inputs(din),
    .cmd_image(cmd_image), .motor_current_pct(cur), .overload_trip(trip),
    .overload_warn(warn), .mon_image(mon_image), .relay_output_a(ra),
    .relay_output_b(rb), .relay_output_c(rc), .aux_supply_output(raux),
    .red_led(red_led), .panel_fault_flash(flash)
  );
  fieldbus_master i_master (.clk_sys(clk_sys), .cmd_image(cmd_image));
  // ==========================================================================
  // Tasks
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task trip_pulse;
    @(posedge clk_sys);
    trip <= 1'b1;
    cyc(2);
    trip <= 1'b0;
    cyc(2);
  endtask : trip_pulse
  task give_verdict;
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Sequence
  initial begin
    cyc(3);
    rst_b <= 1'b1;
    cyc(2);
    check("relay a b", 32'h2, {ra, rb});
    apb(OFF_CTRL, 1'b0, 32'h0);
    check("ctrl reset", 32'h1, rd);
    apb(OFF_COOL_TIME, 1'b0, 32'h0);
    check("cool reset", 32'h64, rd);
    apb(OFF_IRQ_ENABLE, 1'b0, 32'h0);
    check("enable reset", 32'h0, rd);
    apb(12'h01C, 1'b0, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    apb(OFF_IRQ_CLEAR, 1'b0, 32'h0);
    check("clear reads", 32'h0, rd);
    $display("Test reset done");
    din <= 6'h25;
    cur <= 16'h0384;
    i_master.set_outs(4'b1001);
    i_master.set_emerg(1'b1);
    cyc(6);
    check("mon status", 32'h9400, mon_image.status);
    check("mon current", 32'h320, mon_image.current);
    check("outs", 32'hB, outs);
    apb(OFF_MON, 1'b1, 32'h0);
    apb(OFF_MON, 1'b0, 32'h0);
    check("mon reg", 32'h03209400, rd);
    cur <= 16'h01F4;
    warn <= 1'b1;
    cyc(6);
    check("mon warn", 32'h9488, mon_image.status);
    check("mon current", 32'h1F4, mon_image.current);
    warn <= 1'b0;
    apb(OFF_IRQ_CLEAR, 1'b1, 32'h7);
    $display("Test images done");
    apb(OFF_COOL_TIME, 1'b1, 32'h3);
    apb(OFF_IRQ_ENABLE, 1'b1, 32'h1);
    apb(OFF_IRQ_STATUS, 1'b0, 32'h0);
    check("irq cleared", 32'h0, rd);
    trip_pulse();
    check("outs cooling", 32'hD, outs);
    check("red led", 32'h1, red_led);
    check("mon fault", 32'h9440, mon_image.status);
    check("irq", 32'h1, irq);
    i_master.pulse_reset();
    apb(OFF_STATE, 1'b0, 32'h0);
    check("state cooling", 32'h1, (rd >> 2) & 32'h3);
    cyc(50);
    apb(OFF_STATE, 1'b0, 32'h0);
    check("state latched", 32'h2, (rd >> 2) & 32'h3);
    check("relay b", 32'h1, rb);
    apb(OFF_IRQ_STATUS, 1'b0, 32'h0);
    check("irq status", 32'h3, rd);
    apb(OFF_IRQ_CLEAR, 1'b1, 32'h1);
    cyc(3);
    check("irq low", 32'h0, irq);
    i_master.pulse_reset();
    cyc(3);
    check("outs run", 32'hB, outs);
    check("red led off", 32'h0, red_led);
    $display("Test trip done");
    apb(OFF_CTRL, 1'b1, 32'h7);
    cyc(3);
    check("fault outs idle", 32'h2, outs);
    trip_pulse();
    i_master.set_outs(4'b0000);
    cyc(3);
    check("fault outs on", 32'hD, outs);
    cyc(50);
    i_master.pulse_reset();
    cyc(3);
    $display("Test fault outputs done");
    apb(OFF_CTRL, 1'b1, 32'h0);
    i_master.set_outs(4'b0110);
    cyc(3);
    check("pass outs", 32'h6, outs);
    trip_pulse();
    i_master.set_outs(4'b1100);
    cyc(3);
    check("pass outs fault", 32'hC, outs);
    check("red led pass", 32'h1, red_led);
    saw0 = 1'b0;
    saw1 = 1'b0;
    // Blink half period is 2500 cycles, so both levels show in 2700
    repeat (2700) begin
      @(posedge clk_sys);
      saw0 = saw0 | (flash === 1'b0);
      saw1 = saw1 | (flash === 1'b1);
    end
    check("flash levels", 32'h3, {saw0, saw1});
    i_master.pulse_reset();
    cyc(3);
    check("flash off", 32'h0, {red_led, flash});
    $display("Test pass-through done");
    rst_b <= 1'b0;
    din <= 6'h1A;
    cyc(2);
    rst_b <= 1'b1;
    cyc(4);
    check("reset outs", 32'hA, outs);
    check("reset mon", 32'h6800, mon_image.status);
    apb(OFF_CTRL, 1'b0, 32'h0);
    check("ctrl after reset", 32'h1, rd);
    $display("Test mid-run reset done");
    give_verdict();
  end
endmodule : motor_relay_io_tb
